// ==== core/sfq_top.sv ====
// serial flash front end: quad/dual fast reads, wrap, continuous mode, page program
`timescale 1ns/1ps
`include "sfq_params.svh"

module sfq_top #(
  parameter int unsigned P_PROG_CYCLES = `SFQ_PROG_CYCLES
) (
  input  wire logic           I_CLK,
  input  wire logic           I_RESET,
  input  wire logic           I_SCLK,
  input  wire logic           I_CS_N,
  input  wire logic [3:0]     I_DATA_LINE_IN,
  input  wire logic           I_QUAD_ENABLE_BIT,
  input  wire logic [4:0]     I_BLOCK_PROTECT,
  input  wire logic [7:0]     I_MEM_RDATA,
  output logic      [3:0]     O_DATA_LINE_OUT,
  output logic      [3:0]     O_DATA_LINE_OE,
  output logic      [23:0]    O_MEM_RADDR,
  output sfq_pkg::sfq_pgm_t   O_PGM,
  output logic                O_WRITE_ENABLE_LATCH,
  output logic                O_WRITE_IN_PROGRESS,
  output logic                O_CONT_READ_ACTIVE,
  output logic      [2:0]     O_WRAP_SETTING_BITS
);

  // ---------------- link domain (serial clock) ----------------
  sfq_pkg::sfq_lstate_t lst_ff;
  sfq_pkg::sfq_cmd_t    cmd_ff;
  sfq_pkg::sfq_lstate_t eff_st;
  sfq_pkg::sfq_cmd_t    eff_cmd;
  logic [4:0]           cnt_ff;
  logic [4:0]           eff_cnt;
  logic [23:0]          sh_ff;
  logic [23:0]          eff_sh;
  logic [23:0]          sh_in;
  logic [2:0]           a_w;
  logic                 addr_last;
  logic                 mode_last;
  logic                 dum_last;
  logic                 d_last;
  logic                 quad_data;
  logic                 rst_l1_ff;
  logic                 rst_l2_ff;
  logic                 qe_l1_ff;
  logic                 qe_l2_ff;
  logic                 wel_l1_ff;
  logic                 wel_l2_ff;
  logic                 wip_l1_ff;
  logic                 wip_l2_ff;
  logic                 cont_ff;
  sfq_pkg::sfq_cmd_t    cont_cmd_ff;
  logic                 wrap_dis_ff;
  logic [1:0]           wrap_len_ff;
  logic [23:0]          rd_addr_ff;
  logic [23:0]          nxt_rd_addr;
  logic [7:0]           wmask;
  logic [7:0]           pbuf [0:`SFQ_PAGE_BYTES-1];
  logic [`SFQ_PAGE_BYTES-1:0] pvalid_ff;
  logic [7:0]           pidx_ff;
  logic [15:0]          pp_page_ff;
  logic                 pp_ok_ff;
  logic                 write_enable_cmd_seen_ff;
  logic [3:0]           nib;
  logic [3:0]           dout_ff;
  logic [3:0]           doe_ff;

  // link reset and static inputs: two flops each on the serial clock
  always_ff @(posedge I_SCLK)
  begin
    rst_l1_ff <= I_RESET;
    rst_l2_ff <= rst_l1_ff;
    qe_l1_ff  <= I_QUAD_ENABLE_BIT;
    qe_l2_ff  <= qe_l1_ff;
    wel_l1_ff <= O_WRITE_ENABLE_LATCH;
    wel_l2_ff <= wel_l1_ff;
    wip_l1_ff <= O_WRITE_IN_PROGRESS;
    wip_l2_ff <= wip_l1_ff;
  end

  // first clock of a frame: continuous mode skips the opcode
  always_comb
  begin
    eff_st  = lst_ff;
    eff_cmd = cmd_ff;
    eff_cnt = cnt_ff;
    eff_sh  = sh_ff;
    if (lst_ff == sfq_pkg::SFQ_L_START)
    begin
      eff_st  = cont_ff ? sfq_pkg::SFQ_L_ADDR : sfq_pkg::SFQ_L_OPC;
      eff_cmd = cont_ff ? cont_cmd_ff : sfq_pkg::SFQ_CMD_NONE;
      eff_cnt = 5'h00;
      eff_sh  = 24'h000000;
    end
  end

  // bits per clock in address, mode and dummy phases
  always_comb
  begin
    a_w = 3'h1;
    if (eff_cmd == sfq_pkg::SFQ_CMD_QIO)
      a_w = 3'h4;
    else if (eff_cmd == sfq_pkg::SFQ_CMD_DIO)
      a_w = 3'h2;
    unique case (a_w)
      3'h4:    sh_in = {eff_sh[19:0], I_DATA_LINE_IN};
      3'h2:    sh_in = {eff_sh[21:0], I_DATA_LINE_IN[1:0]};
      default: sh_in = {eff_sh[22:0], I_DATA_LINE_IN[0]};
    endcase
  end

  assign addr_last = (a_w == 3'h4) ? (eff_cnt == 5'h05) :
                     (a_w == 3'h2) ? (eff_cnt == 5'h0B) : (eff_cnt == 5'h17);
  assign mode_last = (a_w == 3'h4) ? (eff_cnt == 5'h01) :
                     (a_w == 3'h2) ? (eff_cnt == 5'h03) : (eff_cnt == 5'h07);
  assign dum_last  = (eff_cmd == sfq_pkg::SFQ_CMD_QOUT) ?
                     (eff_cnt == 5'(`SFQ_QOUT_DUMMY_CLKS - 1)) :
                     (eff_cnt == 5'(`SFQ_QIO_DUMMY_CLKS - 1));
  assign quad_data = (eff_cmd == sfq_pkg::SFQ_CMD_QOUT) || (eff_cmd == sfq_pkg::SFQ_CMD_QIO);
  assign d_last    = quad_data ? (eff_cnt == 5'h01) : (eff_cnt == 5'h03);

  // frame sequencer; select high resets it to the start phase
  always_ff @(posedge I_SCLK or posedge I_CS_N)
  begin
    if (I_CS_N)
    begin
      lst_ff <= sfq_pkg::SFQ_L_START;
      cmd_ff <= sfq_pkg::SFQ_CMD_NONE;
      cnt_ff <= 5'h00;
      sh_ff  <= 24'h000000;
    end
    else
    begin
      sh_ff  <= sh_in;
      cmd_ff <= eff_cmd;
      cnt_ff <= eff_cnt + 5'h01;
      lst_ff <= eff_st;
      unique case (eff_st)
        sfq_pkg::SFQ_L_OPC:
          if (eff_cnt == 5'h07)
          begin
            cnt_ff <= 5'h00;
            lst_ff <= sfq_pkg::SFQ_L_ADDR;
            unique case (sh_in[7:0])
              `SFQ_OP_QUAD_OUT_READ:
                if (qe_l2_ff)
                  cmd_ff <= sfq_pkg::SFQ_CMD_QOUT;
                else
                  lst_ff <= sfq_pkg::SFQ_L_IGNORE;
              `SFQ_OP_QUAD_IO_READ:
                if (qe_l2_ff)
                  cmd_ff <= sfq_pkg::SFQ_CMD_QIO;
                else
                  lst_ff <= sfq_pkg::SFQ_L_IGNORE;
              `SFQ_OP_DUAL_IO_READ:
                cmd_ff <= sfq_pkg::SFQ_CMD_DIO;
              `SFQ_OP_SET_WRAP:
                cmd_ff <= sfq_pkg::SFQ_CMD_WRAP;
              `SFQ_OP_PAGE_PROGRAM:
                if (wel_l2_ff && !wip_l2_ff)
                  cmd_ff <= sfq_pkg::SFQ_CMD_PP;
                else
                  lst_ff <= sfq_pkg::SFQ_L_IGNORE;
              default:
                lst_ff <= sfq_pkg::SFQ_L_IGNORE;
            endcase
          end
        sfq_pkg::SFQ_L_ADDR:
          if (addr_last)
          begin
            cnt_ff <= 5'h00;
            unique case (eff_cmd)
              sfq_pkg::SFQ_CMD_DIO,
              sfq_pkg::SFQ_CMD_QIO:  lst_ff <= sfq_pkg::SFQ_L_MODE;
              sfq_pkg::SFQ_CMD_QOUT: lst_ff <= sfq_pkg::SFQ_L_DUMMY;
              sfq_pkg::SFQ_CMD_WRAP: lst_ff <= sfq_pkg::SFQ_L_WBITS;
              sfq_pkg::SFQ_CMD_PP:   lst_ff <= sfq_pkg::SFQ_L_PPDATA;
              default:               lst_ff <= sfq_pkg::SFQ_L_IGNORE;
            endcase
          end
        sfq_pkg::SFQ_L_MODE:
          if (mode_last)
          begin
            cnt_ff <= 5'h00;
            lst_ff <= (eff_cmd == sfq_pkg::SFQ_CMD_QIO) ? sfq_pkg::SFQ_L_DUMMY
                                                        : sfq_pkg::SFQ_L_DATA;
          end
        sfq_pkg::SFQ_L_DUMMY:
          if (dum_last)
          begin
            cnt_ff <= 5'h00;
            lst_ff <= sfq_pkg::SFQ_L_DATA;
          end
        sfq_pkg::SFQ_L_DATA:
          if (d_last)
            cnt_ff <= 5'h00;
        sfq_pkg::SFQ_L_WBITS:
          if (eff_cnt == 5'h07)
            lst_ff <= sfq_pkg::SFQ_L_IGNORE;
        sfq_pkg::SFQ_L_PPDATA:
          if (eff_cnt == 5'h07)
            cnt_ff <= 5'h00;
        default:
          cnt_ff <= 5'h00;
      endcase
    end
  end

  // continuous mode and wrap setting survive frames; link reset only
  always_ff @(posedge I_SCLK)
  begin
    if (rst_l2_ff)
    begin
      cont_ff     <= 1'h0;
      cont_cmd_ff <= sfq_pkg::SFQ_CMD_NONE;
      wrap_dis_ff <= `SFQ_WRAP_DIS_RESET;
      wrap_len_ff <= `SFQ_WRAP_LEN_RESET;
    end
    else
    begin
      // an all-ones reset pattern lands here with mode bits 11 and clears the mode
      if (eff_st == sfq_pkg::SFQ_L_MODE && mode_last)
      begin
        cont_ff     <= (sh_in[`SFQ_CONT_MSB:`SFQ_CONT_LSB] == `SFQ_CONT_KEEP);
        cont_cmd_ff <= eff_cmd;
      end
      if (eff_st == sfq_pkg::SFQ_L_WBITS && eff_cnt == 5'h07)
      begin
        wrap_dis_ff <= sh_in[`SFQ_WRAP_DIS_BIT];
        wrap_len_ff <= sh_in[`SFQ_WRAP_LEN_MSB:`SFQ_WRAP_LEN_LSB];
      end
    end
  end

  // wrap section mask from the length field
  always_comb
  begin
    unique case (wrap_len_ff)
      2'h0: wmask = 8'h07;
      2'h1: wmask = 8'h0F;
      2'h2: wmask = 8'h1F;
      2'h3: wmask = 8'h3F;
    endcase
    nxt_rd_addr = rd_addr_ff + 24'h000001;
    if (eff_cmd == sfq_pkg::SFQ_CMD_QIO && !wrap_dis_ff)
      nxt_rd_addr = {rd_addr_ff[23:8],
                     (rd_addr_ff[7:0] & ~wmask) | (nxt_rd_addr[7:0] & wmask)};
  end

  // read address: loaded after the address phase, stepped per byte
  always_ff @(posedge I_SCLK)
  begin
    if (rst_l2_ff)
      rd_addr_ff <= 24'h000000;
    else if (eff_st == sfq_pkg::SFQ_L_ADDR && addr_last)
      rd_addr_ff <= sh_in;
    else if (lst_ff == sfq_pkg::SFQ_L_DATA && d_last)
      rd_addr_ff <= nxt_rd_addr;
  end

  // page buffer: in-page index wraps, later bytes overwrite earlier ones
  always_ff @(posedge I_SCLK)
  begin
    // only an accepted program may touch the buffer; the engine may still be reading it
    if (eff_st == sfq_pkg::SFQ_L_OPC && eff_cnt == 5'h07
        && sh_in[7:0] == `SFQ_OP_PAGE_PROGRAM && wel_l2_ff && !wip_l2_ff)
      pvalid_ff <= '0;
    if (eff_st == sfq_pkg::SFQ_L_ADDR && addr_last && eff_cmd == sfq_pkg::SFQ_CMD_PP)
    begin
      pidx_ff    <= sh_in[7:0];
      pp_page_ff <= sh_in[23:8];
    end
    else if (eff_st == sfq_pkg::SFQ_L_PPDATA && eff_cnt == 5'h07)
    begin
      pbuf[pidx_ff]      <= sh_in[7:0];
      pvalid_ff[pidx_ff] <= 1'h1;
      pidx_ff            <= pidx_ff + 8'h01;
    end
  end

  // frame-end flags: stand after select rises, cleared on next frame's first clock
  always_ff @(posedge I_SCLK)
  begin
    if (rst_l2_ff || lst_ff == sfq_pkg::SFQ_L_START)
    begin
      write_enable_cmd_seen_ff <= 1'h0;
      pp_ok_ff     <= 1'h0;
    end
    else
    begin
      if (eff_st == sfq_pkg::SFQ_L_OPC && eff_cnt == 5'h07)
        write_enable_cmd_seen_ff <= (sh_in[7:0] == `SFQ_OP_WRITE_ENABLE);
      if (eff_st == sfq_pkg::SFQ_L_PPDATA)
        pp_ok_ff <= (eff_cnt == 5'h07);
    end
  end

  // data nibble for the current slot, msb group first
  always_comb
  begin
    nib = 4'h0;
    if (quad_data)
      nib = cnt_ff[0] ? I_MEM_RDATA[3:0] : I_MEM_RDATA[7:4];
    else
      unique case (cnt_ff[1:0])
        2'h0: nib = {2'h0, I_MEM_RDATA[7:6]};
        2'h1: nib = {2'h0, I_MEM_RDATA[5:4]};
        2'h2: nib = {2'h0, I_MEM_RDATA[3:2]};
        2'h3: nib = {2'h0, I_MEM_RDATA[1:0]};
      endcase
  end

  // outputs launch on the falling edge so the host samples them on the rise
  always_ff @(negedge I_SCLK or posedge I_CS_N)
  begin
    if (I_CS_N)
    begin
      dout_ff <= 4'h0;
      doe_ff  <= 4'h0;
    end
    else if (lst_ff == sfq_pkg::SFQ_L_DATA)
    begin
      dout_ff <= nib;
      doe_ff  <= quad_data ? 4'hF : 4'h3;
    end
    else
    begin
      dout_ff <= 4'h0;
      doe_ff  <= 4'h0;
    end
  end

  assign O_DATA_LINE_OUT     = dout_ff;
  assign O_DATA_LINE_OE      = doe_ff;
  assign O_MEM_RADDR         = rd_addr_ff;
  assign O_CONT_READ_ACTIVE  = cont_ff;
  assign O_WRAP_SETTING_BITS = {wrap_len_ff, wrap_dis_ff};

  // ---------------- system domain ----------------
  sfq_pkg::sfq_sstate_t sst_ff;
  logic                 cs1_ff;
  logic                 cs2_ff;
  logic                 cs3_ff;
  logic [4:0]           bp1_ff;
  logic [4:0]           bp2_ff;
  logic                 cs_rise;
  logic                 prot;
  logic                 prog_start;
  logic [5:0]           psize;
  logic                 wel_ff;
  logic [8:0]           widx_ff;
  logic [31:0]          tmr_ff;
  sfq_pkg::sfq_pgm_t    pgm_ff;

  // select and protect bits cross on two flops; third flop is edge history
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      cs1_ff <= 1'h1;
      cs2_ff <= 1'h1;
      cs3_ff <= 1'h1;
      bp1_ff <= 5'h00;
      bp2_ff <= 5'h00;
    end
    else
    begin
      cs1_ff <= I_CS_N;
      cs2_ff <= cs1_ff;
      cs3_ff <= cs2_ff;
      bp1_ff <= I_BLOCK_PROTECT;
      bp2_ff <= bp1_ff;
    end
  end

  assign cs_rise = cs2_ff && !cs3_ff;

  // protected region: bits 2..0 size in 64K blocks, bit 3 picks bottom
  always_comb
  begin
    psize = 6'h00;
    if (bp2_ff[2:0] != 3'h0)
      psize = 6'h01 << (bp2_ff[2:0] - 3'h1);
    if (bp2_ff[3])
      prot = ({1'h0, pp_page_ff[12:8]} < psize);
    else
      prot = ({1'h0, pp_page_ff[12:8]} >= (6'h20 - psize)) && (psize != 6'h00);
  end

  // frame flags are static while select is high, so they are read here directly
  assign prog_start = cs_rise && pp_ok_ff && wel_ff && !prot
                      && (sst_ff == sfq_pkg::SFQ_S_IDLE);

  // write enable latch
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
      wel_ff <= 1'h0;
    else if (prog_start)
      wel_ff <= 1'h0;
    else if (cs_rise && write_enable_cmd_seen_ff)
      wel_ff <= 1'h1;
  end

  // self-timed program cycle; page bytes stream out in the first 256 cycles
  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      sst_ff  <= sfq_pkg::SFQ_S_IDLE;
      tmr_ff  <= 32'h0;
      widx_ff <= 9'h000;
      pgm_ff  <= '0;
    end
    else
    begin
      pgm_ff.we <= 1'h0;
      unique case (sst_ff)
        sfq_pkg::SFQ_S_IDLE:
          if (prog_start)
          begin
            sst_ff  <= sfq_pkg::SFQ_S_BUSY;
            tmr_ff  <= 32'h0;
            widx_ff <= 9'h000;
          end
        sfq_pkg::SFQ_S_BUSY:
        begin
          tmr_ff <= tmr_ff + 32'h1;
          if (!widx_ff[8])
          begin
            pgm_ff.we   <= pvalid_ff[widx_ff[7:0]];
            pgm_ff.addr <= {pp_page_ff, widx_ff[7:0]};
            pgm_ff.data <= pbuf[widx_ff[7:0]];
            widx_ff     <= widx_ff + 9'h001;
          end
          if (tmr_ff >= P_PROG_CYCLES - 1 && widx_ff[8])
            sst_ff <= sfq_pkg::SFQ_S_IDLE;
        end
      endcase
    end
  end

  assign O_PGM                = pgm_ff;
  assign O_WRITE_ENABLE_LATCH = wel_ff;
  assign O_WRITE_IN_PROGRESS  = (sst_ff == sfq_pkg::SFQ_S_BUSY);

  // ---------------- checks ----------------
  property p_start_busy;
    @(posedge I_CLK) disable iff (I_RESET)
    prog_start |=> O_WRITE_IN_PROGRESS [*2];
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("no busy after start");

  property p_wel_clear;
    @(posedge I_CLK) disable iff (I_RESET)
    prog_start |=> !O_WRITE_ENABLE_LATCH;
  endproperty
  a_wel_clear: assert property (p_wel_clear) else $error("latch kept after start");

  property p_needs_wel;
    @(posedge I_CLK) disable iff (I_RESET)
    $rose(O_WRITE_IN_PROGRESS) |-> $past(O_WRITE_ENABLE_LATCH);
  endproperty
  a_needs_wel: assert property (p_needs_wel) else $error("program without latch");

  property p_no_restart;
    @(posedge I_CLK) disable iff (I_RESET)
    (O_WRITE_IN_PROGRESS && cs_rise) |=> !O_WRITE_IN_PROGRESS || tmr_ff != 32'h0;
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("start while busy");

  property p_protect;
    @(posedge I_CLK) disable iff (I_RESET)
    (cs_rise && prot) |=> !O_WRITE_IN_PROGRESS || $past(O_WRITE_IN_PROGRESS);
  endproperty
  a_protect: assert property (p_protect) else $error("protected page programmed");

  property p_write_enable_cmd;
    @(posedge I_CLK) disable iff (I_RESET)
    (cs_rise && write_enable_cmd_seen_ff) |=> O_WRITE_ENABLE_LATCH;
  endproperty
  a_write_enable_cmd: assert property (p_write_enable_cmd) else $error("latch not set");

  property p_pgm_in_page;
    @(posedge I_CLK) disable iff (I_RESET)
    O_PGM.we |-> (O_PGM.addr[23:8] == pp_page_ff) && O_WRITE_IN_PROGRESS;
  endproperty
  a_pgm_in_page: assert property (p_pgm_in_page) else $error("write left page");

  property p_addr_inc;
    @(posedge I_SCLK) disable iff (I_CS_N || rst_l2_ff)
    (lst_ff == sfq_pkg::SFQ_L_DATA && d_last && (wrap_dis_ff || cmd_ff != sfq_pkg::SFQ_CMD_QIO))
      |=> rd_addr_ff == $past(rd_addr_ff) + 24'h000001;
  endproperty
  a_addr_inc: assert property (p_addr_inc) else $error("read address not stepped");

  property p_wrap;
    @(posedge I_SCLK) disable iff (I_CS_N || rst_l2_ff)
    (lst_ff == sfq_pkg::SFQ_L_DATA && d_last && !wrap_dis_ff && cmd_ff == sfq_pkg::SFQ_CMD_QIO)
      |=> (rd_addr_ff & ~{16'h0000, wmask}) == ($past(rd_addr_ff) & ~{16'h0000, wmask});
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap left section");

  property p_quad_gate;
    @(posedge I_SCLK) disable iff (I_CS_N || rst_l2_ff)
    (lst_ff == sfq_pkg::SFQ_L_DATA && quad_data) |-> qe_l2_ff || $past(qe_l2_ff, 3);
  endproperty
  a_quad_gate: assert property (p_quad_gate) else $error("quad read without enable");

  c_program: cover property (@(posedge I_CLK) disable iff (I_RESET) prog_start);
  c_cont: cover property (@(posedge I_SCLK) disable iff (I_CS_N)
    lst_ff == sfq_pkg::SFQ_L_START ##1 lst_ff == sfq_pkg::SFQ_L_ADDR && cont_ff);
  c_wrap: cover property (@(posedge I_SCLK) disable iff (I_CS_N)
    lst_ff == sfq_pkg::SFQ_L_DATA && !wrap_dis_ff && cmd_ff == sfq_pkg::SFQ_CMD_QIO);

endmodule : sfq_top

// ==== core/sfq_params.svh ====
// constants for the multi-io read and page program front end
`ifndef SFQ_PARAMS_SVH
`define SFQ_PARAMS_SVH

// opcodes
`define SFQ_OP_WRITE_ENABLE   8'h06
`define SFQ_OP_QUAD_OUT_READ  8'h6B
`define SFQ_OP_DUAL_IO_READ   8'hBB
`define SFQ_OP_QUAD_IO_READ   8'hEB
`define SFQ_OP_SET_WRAP       8'h77
`define SFQ_OP_PAGE_PROGRAM   8'h02

// continuous read: bits five and four of the mode byte
`define SFQ_CONT_MSB          5
`define SFQ_CONT_LSB          4
`define SFQ_CONT_KEEP         2'h2

// wrap setting byte fields
`define SFQ_WRAP_DIS_BIT      4
`define SFQ_WRAP_LEN_MSB      6
`define SFQ_WRAP_LEN_LSB      5
`define SFQ_WRAP_DIS_RESET    1'h1
`define SFQ_WRAP_LEN_RESET    2'h0

// phase lengths: address and mode in bits, dummy in serial clocks, page in bytes
`define SFQ_ADDR_BITS         24
`define SFQ_MODE_BITS         8
`define SFQ_QOUT_DUMMY_CLKS   8
`define SFQ_QIO_DUMMY_CLKS    4
`define SFQ_PAGE_BYTES        256

// self-timed program cycle
`define SFQ_CLK_PERIOD_NS     5
`define SFQ_TPP_NS            600000
`define SFQ_PROG_CYCLES       (`SFQ_TPP_NS / `SFQ_CLK_PERIOD_NS)

`endif

// ==== core/sfq_pkg.sv ====
// types for the multi-io read and page program front end
package sfq_pkg;

  // command decoded for the current frame
  typedef enum logic [2:0] {
    SFQ_CMD_NONE  = 3'h0,
    SFQ_CMD_QOUT  = 3'h1,
    SFQ_CMD_DIO   = 3'h2,
    SFQ_CMD_QIO   = 3'h3,
    SFQ_CMD_WRAP  = 3'h4,
    SFQ_CMD_PP    = 3'h5
  } sfq_cmd_t;

  // link-side frame phases
  typedef enum logic [3:0] {
    SFQ_L_START  = 4'h0,
    SFQ_L_OPC    = 4'h1,
    SFQ_L_ADDR   = 4'h2,
    SFQ_L_MODE   = 4'h3,
    SFQ_L_DUMMY  = 4'h4,
    SFQ_L_DATA   = 4'h5,
    SFQ_L_WBITS  = 4'h6,
    SFQ_L_PPDATA = 4'h7,
    SFQ_L_IGNORE = 4'h8
  } sfq_lstate_t;

  // program engine states
  typedef enum logic [0:0] {
    SFQ_S_IDLE = 1'h0,
    SFQ_S_BUSY = 1'h1
  } sfq_sstate_t;

  // byte write toward the array
  typedef struct packed {
    logic        we;
    logic [23:0] addr;
    logic [7:0]  data;
  } sfq_pgm_t;

endpackage : sfq_pkg

// ==== dv/sfq_host.sv ====
// host controller model: mode 0 frames on a 64 ns serial clock
`timescale 1ns/1ps
module sfq_host (
  output logic            o_sclk = 1'b0,
  output logic            o_cs_n = 1'b1,
  output logic      [3:0] o_dio = 4'h0,
  input  wire logic [3:0] i_dio
);
  // n clocks of w bits, msb first; r reads, and lines it releases toggle
  task automatic xf(int w, int n, logic [31:0] v, bit r, output logic [7:0] b);
    o_cs_n = 1'b0;
    repeat (n)
    begin
      o_dio = r ? ~o_dio : w > 2 ? v[31:28] :
              {~o_dio[3:2], w > 1 ? v[31:30] : {~o_dio[1], v[31]}};
      #32 o_sclk = 1'b1;
      b = w > 2 ? {b[3:0], i_dio} : {b[5:0], i_dio[1:0]};
      #32 o_sclk = 1'b0;
      v = v << w;
    end
  endtask : xf
  // gap lets the system clock side see select high
  task automatic desel();
    #8 o_cs_n = 1'b1;
    #48;
  endtask : desel
  task automatic idle(int n);
    repeat (2 * n) #32 o_sclk = ~o_sclk;
  endtask : idle
endmodule : sfq_host

// ==== dv/tb.sv ====
// self-checking bench for the serial flash front end
`timescale 1ns/1ps
module tb;
  logic I_CLK = 1'b0, I_RESET = 1'b1, qe = 1'b1, sclk, cs_n, write_enable_latch, write_in_progress, cont;
  logic [3:0] hd, dout, doe;
  logic [2:0] wrap;
  logic [4:0] bp = 5'h00;
  logic [7:0] b;
  logic [23:0] ra;
  sfq_pkg::sfq_pgm_t pgm;
  logic [31:0] wq[$];
  int errors = 0, checks = 0;
  // the design owns a line only while it enables it
  wire [3:0] dl = doe & dout | ~doe & hd;
  sfq_host hst (.o_sclk(sclk), .o_cs_n(cs_n), .o_dio(hd), .i_dio(dl));
  // array model: scrambled low address byte; protection driven late in the run
  sfq_top #(.P_PROG_CYCLES(300)) i_dut (.I_CLK(I_CLK), .I_RESET(I_RESET), .I_SCLK(sclk),
    .I_CS_N(cs_n), .I_DATA_LINE_IN(dl), .I_QUAD_ENABLE_BIT(qe), .I_BLOCK_PROTECT(bp),
    .I_MEM_RDATA(ra[7:0] ^ 8'h5A), .O_DATA_LINE_OUT(dout), .O_DATA_LINE_OE(doe),
    .O_MEM_RADDR(ra), .O_PGM(pgm), .O_WRITE_ENABLE_LATCH(write_enable_latch), .O_WRITE_IN_PROGRESS(write_in_progress),
    .O_CONT_READ_ACTIVE(cont), .O_WRAP_SETTING_BITS(wrap));
  initial forever #2.5 I_CLK = ~I_CLK;
  // log of array writes
  always @(posedge I_CLK)
    if (pgm.we === 1'b1)
      wq.push_back({pgm.addr, pgm.data});
  task automatic chk(logic [31:0] g, logic [31:0] e);
    checks++;
    errors += int'(g !== e);
    if (g !== e)
      $display("unexpected at %0t: %h not %h", $time, g, e);
  endtask : chk
  task automatic end_of_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic wait_wip(logic v);
    for (int k = 0; k < 400 && write_in_progress !== v; k++)
      @(posedge I_CLK);
    chk(write_in_progress, v);
    if (write_in_progress !== v)
      end_of_test();
  endtask : wait_wip
  // opcode on line zero, then n clocks of w bits
  task automatic cmd(logic [7:0] op, int w, int n, logic [31:0] v, bit e);
    hst.xf(1, 8, {op, 24'h0}, 0, b);
    hst.xf(w, n, v, 0, b);
    if (e)
      hst.desel();
  endtask : cmd
  // n bytes from a; only address bits under m advance
  task automatic rd(int w, int n, logic [23:0] a, logic [23:0] m);
    for (int k = 0; k < n; k++)
    begin
      hst.xf(w, 8 / w, 32'h0, 1, b);
      chk(b, 8'(a & ~m | 24'(a + k) & m) ^ 8'h5A);
    end
    hst.desel();
  endtask : rd
  initial
  begin
    hst.idle(4);
    @(posedge I_CLK) #1 I_RESET = 1'b0;
    hst.idle(3);
    chk({write_enable_latch, write_in_progress, cont, wrap}, 32'h1);
    cmd(8'h6B, 1, 32, 32'hFE00, 0);
    rd(4, 3, 24'hFE, 24'hFFFFFF);
    qe = 1'b0;
    cmd(8'hEB, 4, 14, 32'h0, 0);
    #1 chk(doe, 4'h0);
    hst.desel();
    qe = 1'b1;
    cmd(8'hBB, 2, 16, 32'h10020, 0);
    rd(2, 2, 24'h100, 24'hFFFFFF);
    chk(cont, 1'b1);
    hst.xf(2, 16, 32'h200FF, 0, b);
    rd(2, 1, 24'h200, 24'hFFFFFF);
    chk(cont, 1'b0);
    cmd(8'h77, 1, 32, 32'h40, 1);
    chk(wrap, 3'h4);
    cmd(8'hEB, 4, 12, 32'h13E20, 0);
    rd(4, 4, 24'h13E, 24'h1F);
    hst.xf(4, 12, 32'h1FFF, 0, b);
    rd(4, 2, 24'h1F, 24'h1F);
    cmd(8'h77, 1, 32, 32'h10, 1);
    chk(wrap, 3'h1);
    cmd(8'h02, 1, 32, 32'h1FFC3, 1);
    chk(write_in_progress, 1'b0);
    cmd(8'h06, 1, 0, 32'h0, 1);
    chk(write_enable_latch, 1'b1);
    cmd(8'h02, 1, 28, 32'h1FFC3, 1);
    chk(write_in_progress, 1'b0);
    cmd(8'h02, 1, 32, 32'h1FFC3, 0);
    cmd(8'h3C, 1, 0, 32'h0, 1);
    wait_wip(1'b1);
    #11 chk(write_enable_latch, 1'b0);
    cmd(8'h06, 1, 0, 32'h0, 1);
    wait_wip(1'b0);
    bp = 5'h01;
    cmd(8'h02, 1, 32, 32'h1F0000A5, 1);
    chk(write_in_progress, 1'b0);
    chk(write_enable_latch, 1'b1);
    chk(wq.size(), 2);
    chk(wq[0], 32'h1003C);
    chk(wq[1], 32'h1FFC3);
    end_of_test();
  end
endmodule : tb
